// File: hw/lookup_ctl_pkg.sv
`default_nettype none
package lookup_ctl_pkg;

  // Register map
  localparam logic [15:0] LOOKUP_CONTROL_ZERO_ADDR = 16'h0310;
  localparam logic [15:0] LOOKUP_CONTROL_ONE_ADDR  = 16'h0311;

  // Control register 0 fields
  localparam int CTL0_VLAN_EN_BIT      = 7;
  localparam int CTL0_DROP_INV_VID_BIT = 6;
  localparam int CTL0_AGE_CNT_HI       = 5;
  localparam int CTL0_AGE_CNT_LO       = 3;
  localparam int CTL0_RSVD_MC_BIT      = 2;
  localparam int CTL0_HASH_HI          = 1;
  localparam int CTL0_HASH_LO          = 0;
  localparam logic [7:0] CTL0_RESET    = 8'h61;

  // Control register 1 fields
  localparam int CTL1_LEARN_DIS_BIT    = 7;
  localparam int CTL1_SELF_FILT_BIT    = 6;
  localparam int CTL1_FLUSH_TABLE_BIT  = 5;
  localparam int CTL1_FLUSH_MSTP_BIT   = 4;
  localparam int CTL1_MC_SRC_FWD_BIT   = 3;
  localparam int CTL1_AGING_EN_BIT     = 2;
  localparam int CTL1_FAST_AGING_BIT   = 1;
  localparam int CTL1_LINK_FLUSH_BIT   = 0;
  localparam logic [7:0] CTL1_RESET    = 8'h0C;

  // Value of the age period after reset, in seconds
  localparam logic [7:0] AGE_PERIOD_RESET = 8'h4B;

  typedef enum logic [1:0] {
    HASH_DIRECT     = 2'h0,
    HASH_CRC        = 2'h1,
    HASH_XOR        = 2'h2,
    HASH_DIRECT_ALT = 2'h3
  } hash_select_t;

  typedef enum logic [1:0] {
    FLUSH_NONE    = 2'h0,
    FLUSH_DYNAMIC = 2'h1,
    FLUSH_STATIC  = 2'h2,
    FLUSH_BOTH    = 2'h3
  } flush_option_t;

  localparam int          HASH_W        = 10;
  localparam logic [9:0]  CRC_POLY      = 10'h233;
  localparam logic [39:0] RSVD_MC_PREFIX = 40'h01_80C2_0000;

  // Timing
  localparam longint CLK_HZ          = 40_000_000;
  localparam longint AGE_UNIT_MS     = 1000;
  localparam longint FAST_AGE_US     = 500;
  localparam longint AGE_UNIT_CYCLES = CLK_HZ / 1000 * AGE_UNIT_MS;
  localparam longint FAST_AGE_CYCLES = CLK_HZ / 1_000_000 * FAST_AGE_US;

endpackage : lookup_ctl_pkg
`default_nettype wire

// File: hw/lookup_engine_control_regs.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// [RL1] VLAN enable bit switches VLAN forwarding and filtering; resets off.
// [RL2] Software fills the VLAN table before setting VLAN enable.
// [RL3] Drop-invalid-VID set discards packets with invalid VLAN identifier.
// [RL4] Drop-invalid-VID clear sends invalid-VID packets to the host port.
// [RL5] Enabled unknown-VID forwarding overrides the drop-invalid-VID choice.
// [RL6] Age count field is loaded into each dynamic entry on update.
// [RL7] Aging time depends on entry age count and the age period.
// [RL8] Aging time is age period seconds times age count; period resets 75.
// [RL9] Reserved multicast table joins lookups only while its enable is set.
// [RL10] Hash select: direct ten low bits, CRC, or XOR indexing.
// [RL11] Unicast learning disable bit stops learning of unicast addresses.
// [RL12] Global self-address filtering drops packets whose source is the switch.
// [RL13] Self filtering only on ports with their own enable set.
// [RL14] Self address is the 48-bit switch address value.
// [RL15] Table flush bit starts a flush and clears itself afterwards.
// [RL16] MSTP flush bit starts a flush of matched entries, self-clearing.
// [RL17] Both flushes limit removal by the flush option setting.
// [RL18] Flush option: 00 none, 01 dynamic, 10 static, 11 both.
// [RL19] Multicast source packets forwarded when bit set, dropped when clear.
// [RL20] Aging enable bit switches address table aging on or off.
// [RL21] Fast aging bit switches fast aging on or off.
// [RL22] Link-down flush removes entries of a port that loses link.
// [RL23] Fast aging expires dynamic entries after a much shorter interval.
module lookup_engine_control_regs #(
  parameter int     PORTS           = 6,
  parameter longint AGE_UNIT_CYCLES = lookup_ctl_pkg::AGE_UNIT_CYCLES,
  parameter longint FAST_AGE_CYCLES = lookup_ctl_pkg::FAST_AGE_CYCLES
) (
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_rst_n,
  // Register port
  input  wire logic [15:0]              i_reg_addr,
  input  wire logic                     i_reg_wr,
  input  wire logic                     i_reg_rd,
  input  wire logic [7:0]               i_reg_wdata,
  output logic      [7:0]               o_reg_rdata,
  // Settings held elsewhere in the switch
  input  wire logic [47:0]              i_switch_addr,
  input  wire logic [7:0]               i_age_period,
  input  wire logic [1:0]               i_flush_option,
  input  wire logic                     i_unknown_vid_fwd_en,
  input  wire logic [PORTS-1:0]         i_port_self_filter_en,
  input  wire logic [PORTS-1:0]         i_link_up,
  // Flush handshake with the table engine
  input  wire logic                     i_flush_done,
  output logic                          o_flush_table,
  output logic                          o_flush_mstp,
  output logic      [1:0]               o_flush_kind,
  output logic      [PORTS-1:0]         o_port_flush,
  // Aging
  output logic      [2:0]               o_entry_age_count,
  output logic      [10:0]              o_age_time_s,
  output logic                          o_age_step,
  // Per-packet decision
  input  wire logic                     i_pkt_valid,
  input  wire logic [$clog2(PORTS)-1:0] i_pkt_port,
  input  wire logic [47:0]              i_pkt_sa,
  input  wire logic [47:0]              i_pkt_da,
  input  wire logic                     i_pkt_vid_invalid,
  output logic                          o_pkt_valid,
  output logic                          o_pkt_drop,
  output logic                          o_pkt_to_host,
  output logic                          o_pkt_unknown_vid,
  output logic                          o_pkt_learn,
  output logic                          o_pkt_rsvd_lookup,
  output logic                          o_vlan_enable,
  output logic      [9:0]               o_pkt_hash_index
);

  localparam int CNT_W = $clog2(AGE_UNIT_CYCLES > FAST_AGE_CYCLES ? AGE_UNIT_CYCLES : FAST_AGE_CYCLES) + 1;
  localparam logic [CNT_W-1:0] UNIT_LAST = CNT_W'(AGE_UNIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] FAST_LAST = CNT_W'(FAST_AGE_CYCLES - 1);

  typedef struct packed {
    logic [7:0]       ctl0;
    logic [7:0]       ctl1;
    logic [7:0]       rdata;
    logic [CNT_W-1:0] tick_cnt;
    logic [7:0]       sec_cnt;
    logic             age_step;
    logic [10:0]      age_time;
    logic [PORTS-1:0] link_q;
    logic [PORTS-1:0] port_flush;
    logic             pkt_valid;
    logic             pkt_drop;
    logic             pkt_host;
    logic             pkt_unknown;
    logic             pkt_learn;
    logic             pkt_rsvd;
    logic [9:0]       pkt_index;
  } state_t;

  state_t     st;
  state_t     next_st;
  logic [9:0] hash_index;
  logic       wr0;
  logic       wr1;
  logic       self_hit;
  logic       mc_src;
  logic       inv_vid;
  logic [PORTS-1:0] link_lost;

  lookup_hash_index u_hash (
    .i_dest_addr   (i_pkt_da),
    .i_hash_select (st.ctl0[lookup_ctl_pkg::CTL0_HASH_HI:lookup_ctl_pkg::CTL0_HASH_LO]),
    .o_index       (hash_index)
  );

  assign wr0 = i_reg_wr && (i_reg_addr == lookup_ctl_pkg::LOOKUP_CONTROL_ZERO_ADDR);
  assign wr1 = i_reg_wr && (i_reg_addr == lookup_ctl_pkg::LOOKUP_CONTROL_ONE_ADDR);
  assign self_hit = st.ctl1[lookup_ctl_pkg::CTL1_SELF_FILT_BIT] && i_port_self_filter_en[i_pkt_port]
                    && (i_pkt_sa == i_switch_addr); // RL12 RL13 RL14
  assign mc_src   = i_pkt_sa[40];
  // Invalid VID only matters while VLAN mode is on
  assign inv_vid  = i_pkt_vid_invalid && st.ctl0[lookup_ctl_pkg::CTL0_VLAN_EN_BIT]; // RL1
  assign link_lost = st.link_q & ~i_link_up;

  always_comb
  begin
    logic drop;
    drop    = 1'b0;
    next_st = st;

    // Register writes; the flush triggers ignore written zeros
    if (wr0)
      next_st.ctl0 = i_reg_wdata;
    if (wr1)
    begin
      next_st.ctl1[7:6] = i_reg_wdata[7:6];
      next_st.ctl1[3:0] = i_reg_wdata[3:0];
    end
    // Done clears, but a new trigger in the same cycle wins
    if (i_flush_done || i_flush_option == lookup_ctl_pkg::FLUSH_NONE) // RL15 RL16 RL18
    begin
      next_st.ctl1[lookup_ctl_pkg::CTL1_FLUSH_TABLE_BIT] = 1'b0;
      next_st.ctl1[lookup_ctl_pkg::CTL1_FLUSH_MSTP_BIT]  = 1'b0;
    end
    if (wr1 && i_reg_wdata[lookup_ctl_pkg::CTL1_FLUSH_TABLE_BIT])
      next_st.ctl1[lookup_ctl_pkg::CTL1_FLUSH_TABLE_BIT] = 1'b1; // RL15
    if (wr1 && i_reg_wdata[lookup_ctl_pkg::CTL1_FLUSH_MSTP_BIT])
      next_st.ctl1[lookup_ctl_pkg::CTL1_FLUSH_MSTP_BIT] = 1'b1; // RL16

    // Read data lags the strobe by one cycle
    if (i_reg_rd)
    begin
      if (i_reg_addr == lookup_ctl_pkg::LOOKUP_CONTROL_ZERO_ADDR)
        next_st.rdata = st.ctl0;
      else if (i_reg_addr == lookup_ctl_pkg::LOOKUP_CONTROL_ONE_ADDR)
        next_st.rdata = st.ctl1;
      else
        next_st.rdata = 8'h00;
    end

    // Aging time base
    next_st.age_step = 1'b0;
    next_st.age_time = 11'(i_age_period)
                       * 11'(st.ctl0[lookup_ctl_pkg::CTL0_AGE_CNT_HI:lookup_ctl_pkg::CTL0_AGE_CNT_LO]); // RL8
    if (!st.ctl1[lookup_ctl_pkg::CTL1_AGING_EN_BIT]) // RL20
    begin
      next_st.tick_cnt = '0;
      next_st.sec_cnt  = '0;
    end
    else if (st.ctl1[lookup_ctl_pkg::CTL1_FAST_AGING_BIT]) // RL21
    begin
      next_st.sec_cnt = '0;
      if (st.tick_cnt >= FAST_LAST)
      begin
        next_st.tick_cnt = '0;
        next_st.age_step = 1'b1; // RL23
      end
      else
        next_st.tick_cnt = st.tick_cnt + 1'b1;
    end
    else if (st.tick_cnt >= UNIT_LAST)
    begin
      next_st.tick_cnt = '0;
      // One step per age period; an entry lives age count steps
      if (i_age_period != 8'h00 && st.sec_cnt >= i_age_period - 8'h01) // RL7 RL8
      begin
        next_st.sec_cnt  = '0;
        next_st.age_step = 1'b1;
      end
      else
        next_st.sec_cnt = st.sec_cnt + 8'h01;
    end
    else
      next_st.tick_cnt = st.tick_cnt + 1'b1;

    // Link-down flush
    next_st.link_q     = i_link_up;
    next_st.port_flush = st.ctl1[lookup_ctl_pkg::CTL1_LINK_FLUSH_BIT] ? link_lost : '0; // RL22

    // Packet decision, registered
    next_st.pkt_valid = i_pkt_valid;
    if (i_pkt_valid)
    begin
      drop = self_hit; // RL12
      if (mc_src && !st.ctl1[lookup_ctl_pkg::CTL1_MC_SRC_FWD_BIT])
        drop = 1'b1; // RL19
      if (inv_vid && !i_unknown_vid_fwd_en && st.ctl0[lookup_ctl_pkg::CTL0_DROP_INV_VID_BIT])
        drop = 1'b1; // RL3
      next_st.pkt_drop    = drop;
      next_st.pkt_unknown = inv_vid && i_unknown_vid_fwd_en; // RL5
      next_st.pkt_host    = !drop && inv_vid && !i_unknown_vid_fwd_en; // RL4
      next_st.pkt_learn   = !drop && !mc_src && !st.ctl1[lookup_ctl_pkg::CTL1_LEARN_DIS_BIT]; // RL11
      next_st.pkt_rsvd    = st.ctl0[lookup_ctl_pkg::CTL0_RSVD_MC_BIT]
                            && (i_pkt_da[47:8] == lookup_ctl_pkg::RSVD_MC_PREFIX); // RL9
      next_st.pkt_index   = hash_index; // RL10
    end
    else
    begin
      next_st.pkt_drop    = 1'b0;
      next_st.pkt_unknown = 1'b0;
      next_st.pkt_host    = 1'b0;
      next_st.pkt_learn   = 1'b0;
      next_st.pkt_rsvd    = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      st            <= '0;
      st.ctl0       <= lookup_ctl_pkg::CTL0_RESET;
      st.ctl1       <= lookup_ctl_pkg::CTL1_RESET;
      st.link_q     <= '0;
    end
    else
      st <= next_st;
  end

  assign o_reg_rdata       = st.rdata;
  assign o_flush_table     = st.ctl1[lookup_ctl_pkg::CTL1_FLUSH_TABLE_BIT];
  assign o_flush_mstp      = st.ctl1[lookup_ctl_pkg::CTL1_FLUSH_MSTP_BIT];
  assign o_flush_kind      = i_flush_option; // RL17
  assign o_port_flush      = st.port_flush;
  assign o_entry_age_count = st.ctl0[lookup_ctl_pkg::CTL0_AGE_CNT_HI:lookup_ctl_pkg::CTL0_AGE_CNT_LO]; // RL6
  assign o_age_time_s      = st.age_time;
  assign o_age_step        = st.age_step;
  assign o_pkt_valid       = st.pkt_valid;
  assign o_pkt_drop        = st.pkt_drop;
  assign o_pkt_to_host     = st.pkt_host;
  assign o_pkt_unknown_vid = st.pkt_unknown;
  assign o_pkt_learn       = st.pkt_learn;
  assign o_pkt_rsvd_lookup = st.pkt_rsvd;
  assign o_vlan_enable     = st.ctl0[lookup_ctl_pkg::CTL0_VLAN_EN_BIT]; // RL1
  assign o_pkt_hash_index  = st.pkt_index; // RL10

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  vlan_gate_a: assert property ( // RL1
    i_pkt_valid && !o_vlan_enable |=> !o_pkt_to_host && !o_pkt_unknown_vid)
    else $error("invalid VID acted on with VLAN mode off");

  invalid_drop_a: assert property ( // RL3
    i_pkt_valid && inv_vid && !i_unknown_vid_fwd_en && st.ctl0[6] |=> o_pkt_drop && !o_pkt_to_host)
    else $error("invalid VID packet not dropped");

  invalid_host_a: assert property ( // RL4
    i_pkt_valid && inv_vid && !i_unknown_vid_fwd_en && !st.ctl0[6] && !self_hit && !mc_src
    |=> o_pkt_to_host && !o_pkt_drop)
    else $error("invalid VID packet not sent to host");

  unknown_over_a: assert property ( // RL5
    i_pkt_valid && inv_vid && i_unknown_vid_fwd_en |=> o_pkt_unknown_vid && !o_pkt_to_host)
    else $error("unknown VID forwarding did not take precedence");

  age_count_a: assert property ( // RL6
    wr0 |=> o_entry_age_count == $past(i_reg_wdata[5:3]))
    else $error("age count not taken from write");

  age_time_a: assert property ( // RL8
    $stable(i_age_period) && !wr0 |=> o_age_time_s == 11'($past(i_age_period)) * 11'(o_entry_age_count))
    else $error("aging time not period times count");

  self_filter_a: assert property ( // RL13
    i_pkt_valid && i_pkt_sa == i_switch_addr && st.ctl1[6] && i_port_self_filter_en[i_pkt_port] |=> o_pkt_drop)
    else $error("self-addressed packet forwarded");

  mc_drop_a: assert property ( // RL19
    i_pkt_valid && i_pkt_sa[40] && !st.ctl1[3] |=> o_pkt_drop && !o_pkt_learn)
    else $error("multicast source packet not dropped");

  learn_off_a: assert property ( // RL11
    i_pkt_valid && st.ctl1[7] |=> !o_pkt_learn)
    else $error("learning while disabled");

  flush_clear_a: assert property ( // RL15
    o_flush_table && i_flush_done && !(wr1 && i_reg_wdata[5]) |=> !o_flush_table)
    else $error("table flush bit did not self-clear");

  flush_start_a: assert property ( // RL16
    wr1 && i_reg_wdata[4] |=> o_flush_mstp)
    else $error("MSTP flush not started");

  aging_off_a: assert property ( // RL20
    !st.ctl1[2] |=> !o_age_step [*2])
    else $error("age step while aging disabled");

  link_flush_a: assert property ( // RL22
    st.ctl1[0] && |link_lost |=> o_port_flush == $past(link_lost))
    else $error("link-down flush missing");

  rsvd_off_a: assert property ( // RL9
    i_pkt_valid && !st.ctl0[2] |=> !o_pkt_rsvd_lookup)
    else $error("reserved multicast lookup while disabled");

  direct_hash_a: assert property ( // RL10
    i_pkt_valid && (st.ctl0[1:0] == 2'h0 || st.ctl0[1:0] == 2'h3) |=> o_pkt_hash_index == $past(i_pkt_da[9:0]))
    else $error("direct index not taken from address");

  flush_none_a: assert property ( // RL18
    o_flush_table && i_flush_option == 2'h0 && !(wr1 && i_reg_wdata[5]) |=> !o_flush_table)
    else $error("table flush held with no flush option");

  mstp_clear_a: assert property ( // RL16
    o_flush_mstp && i_flush_done && !(wr1 && i_reg_wdata[4]) |=> !o_flush_mstp)
    else $error("MSTP flush bit did not self-clear");

  self_off_a: assert property ( // RL12
    i_pkt_valid && !st.ctl1[6] && !mc_src && !inv_vid |=> !o_pkt_drop)
    else $error("packet dropped with self filtering off");

  ctl1_read_a: assert property ( // RL15 RL16
    i_reg_rd && i_reg_addr == lookup_ctl_pkg::LOOKUP_CONTROL_ONE_ADDR |=> o_reg_rdata == $past(st.ctl1))
    else $error("control register 1 read back wrong");

  fast_step_a: assert property ( // RL21 RL23
    st.ctl1[2] && st.ctl1[1] && st.tick_cnt == FAST_LAST |=> o_age_step)
    else $error("fast aging step missing");

  drop_seen_c: cover property (o_pkt_valid && o_pkt_drop);
  host_seen_c: cover property (o_pkt_valid && o_pkt_to_host);
  flush_done_c: cover property (o_flush_table ##[1:20] !o_flush_table);
  age_step_c: cover property (o_age_step);
  fast_step_c: cover property (o_age_step && st.ctl1[1]);

endmodule : lookup_engine_control_regs
`default_nettype wire

// File: hw/lookup_hash_index.sv
`timescale 1ns/10ps
`default_nettype none
module lookup_hash_index (
  input  wire logic [47:0] i_dest_addr,
  input  wire logic [1:0]  i_hash_select,
  output logic      [9:0]  o_index
);

  logic [9:0] crc;
  logic [9:0] fold;
  logic [59:0] padded;

  always_comb
  begin
    crc    = '0;
    fold   = '0;
    padded = {12'h000, i_dest_addr};
    for (int i = 47; i >= 0; i--)
    begin
      if (crc[9] ^ i_dest_addr[i])
        crc = {crc[8:0], 1'b0} ^ lookup_ctl_pkg::CRC_POLY;
      else
        crc = {crc[8:0], 1'b0};
    end
    for (int j = 0; j < 6; j++)
      fold = fold ^ padded[j*10 +: 10];
    case (lookup_ctl_pkg::hash_select_t'(i_hash_select))
      lookup_ctl_pkg::HASH_CRC: o_index = crc;        // RL10
      lookup_ctl_pkg::HASH_XOR: o_index = fold;       // RL10
      default:                  o_index = i_dest_addr[9:0]; // RL10
    endcase
  end

endmodule : lookup_hash_index
`default_nettype wire

// File: testbench/lookup_engine_control_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
module lookup_engine_control_regs_bench;
  localparam logic [47:0] SELF = 48'h0012_3456_789A;
  localparam logic [47:0] UNI  = 48'h0200_0000_0001;
  localparam logic [47:0] MCS  = 48'h0100_0000_0001;
  localparam logic [47:0] DN   = 48'h00AA_BBCC_D155;
  localparam logic [47:0] DR   = 48'h0180_C200_0003;

  typedef struct packed {
    logic [7:0]  c0;
    logic [7:0]  c1;
    logic [47:0] s;
    logic [47:0] d;
    logic        vi;
    logic        uk;
    logic [5:0]  pf;
    logic [4:0]  exp;
  } pkt_row_t;

  logic        clk, rst_n, reg_wr, reg_rd, unk_en, flush_done, pkt_valid, vinv;
  logic [15:0] reg_addr;
  logic [7:0]  wdata, rdata, age_period;
  logic [1:0]  flush_opt, flush_kind;
  logic [5:0]  pf_en, link_up, port_flush;
  logic [2:0]  pkt_port, age_cnt;
  logic [47:0] sa, da;
  logic [10:0] age_time;
  logic [9:0]  hidx;
  logic        f_tab, f_mstp, age_step, o_valid, o_drop, o_host, o_unk, o_learn, o_rsvd, vlan_en;
  int          error_cnt = 0;
  int          checked   = 0;
  int          cnt;

  // Flags are {drop, to_host, unknown_vid, learn, rsvd_lookup}
  pkt_row_t rows [10] = '{
    '{8'h60, 8'h0C, UNI, DN, 1'b1, 1'b0, 6'h3F, 5'b00010},
    '{8'hE3, 8'h0C, UNI, DN, 1'b1, 1'b0, 6'h3F, 5'b10000},
    '{8'hA0, 8'h0C, UNI, DN, 1'b1, 1'b0, 6'h3F, 5'b01010},
    '{8'hE0, 8'h0C, UNI, DN, 1'b1, 1'b1, 6'h3F, 5'b00110},
    '{8'h64, 8'h4C, SELF, DR, 1'b0, 1'b0, 6'h3F, 5'b10001},
    '{8'h60, 8'h0C, SELF, DR, 1'b0, 1'b0, 6'h3F, 5'b00010},
    '{8'h63, 8'h4C, SELF, DN, 1'b0, 1'b0, 6'h3B, 5'b00010},
    '{8'h60, 8'h04, MCS, DN, 1'b0, 1'b0, 6'h3F, 5'b10000},
    '{8'h61, 8'h0C, MCS, DN, 1'b0, 1'b0, 6'h3F, 5'b00000},
    '{8'h62, 8'h8C, UNI, DN, 1'b0, 1'b0, 6'h3F, 5'b00000}
  };

  lookup_engine_control_regs #(
    .PORTS           (6),
    .AGE_UNIT_CYCLES (20),
    .FAST_AGE_CYCLES (4)
  ) uut (
    .i_ref_clk             (clk),
    .i_rst_n               (rst_n),
    .i_reg_addr            (reg_addr),
    .i_reg_wr              (reg_wr),
    .i_reg_rd              (reg_rd),
    .i_reg_wdata           (wdata),
    .o_reg_rdata           (rdata),
    .i_switch_addr         (SELF),
    .i_age_period          (age_period),
    .i_flush_option        (flush_opt),
    .i_unknown_vid_fwd_en  (unk_en),
    .i_port_self_filter_en (pf_en),
    .i_link_up             (link_up),
    .i_flush_done          (flush_done),
    .o_flush_table         (f_tab),
    .o_flush_mstp          (f_mstp),
    .o_flush_kind          (flush_kind),
    .o_port_flush          (port_flush),
    .o_entry_age_count     (age_cnt),
    .o_age_time_s          (age_time),
    .o_age_step            (age_step),
    .i_pkt_valid           (pkt_valid),
    .i_pkt_port            (pkt_port),
    .i_pkt_sa              (sa),
    .i_pkt_da              (da),
    .i_pkt_vid_invalid     (vinv),
    .o_pkt_valid           (o_valid),
    .o_pkt_drop            (o_drop),
    .o_pkt_to_host         (o_host),
    .o_pkt_unknown_vid     (o_unk),
    .o_pkt_learn           (o_learn),
    .o_pkt_rsvd_lookup     (o_rsvd),
    .o_vlan_enable         (vlan_en),
    .o_pkt_hash_index      (hidx)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic end_of_test;
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Index the table engine should get: CRC is MSB first from zero, XOR folds 10-bit slices
  function automatic logic [9:0] exp_index(input logic [47:0] d, input logic [1:0] sel);
    logic [9:0] c;
    c = 10'h000;
    for (int i = 47; i >= 0; i--)
      c = {c[8:0], 1'b0} ^ ((c[9] ^ d[i]) ? lookup_ctl_pkg::CRC_POLY : 10'h000);
    case (sel)
      2'h1:    return c;
      2'h2:    return d[9:0] ^ d[19:10] ^ d[29:20] ^ d[39:30] ^ {2'h0, d[47:40]};
      default: return d[9:0];
    endcase
  endfunction : exp_index

  // Strobe dropped and one idle edge left, so back-to-back calls never re-drive in one step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr = a;
    wdata    = d;
    reg_wr   = 1'b1;
    @(negedge clk);
    reg_wr   = 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    chk("reg_rdata", 48'(e), 48'(rdata));
    @(negedge clk);
  endtask : rd_chk

  task automatic link_drop(input logic [5:0] lu, input logic [5:0] e);
    logic [5:0] seen;
    int         hits;
    seen    = '0;
    hits    = 0;
    link_up = 6'h3F;
    repeat (3) @(negedge clk);
    link_up = lu;
    repeat (3)
    begin
      @(negedge clk);
      seen = seen | port_flush;
      if (port_flush !== 6'h00)
        hits++;
    end
    chk("port_flush", 48'(e), 48'(seen));
    chk("port_flush_pulses", 48'(e != 6'h00), 48'(hits));
  endtask : link_drop

  task automatic age_gap(input int e);
    int n;
    n = 0;
    while (age_step !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (age_step !== 1'b1 && n < 300);
    chk("age_gap", 48'(e), 48'(n));
  endtask : age_gap

  // Generous bound: the whole sequence needs well under 2000 cycles
  initial
  begin
    #500000;
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    {rst_n, reg_wr, reg_rd, unk_en, flush_done, pkt_valid, vinv} = '0;
    reg_addr   = 16'h0000;
    wdata      = 8'h00;
    age_period = 8'h4B;
    flush_opt  = 2'b01;
    pf_en      = 6'h3F;
    link_up    = 6'h3F;
    pkt_port   = 3'h2;
    sa         = UNI;
    da         = DN;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    rd_chk(16'h0310, 8'h61);
    rd_chk(16'h0311, 8'h0C);
    chk("age_count", 48'h4, 48'(age_cnt));
    rd_chk(16'h0312, 8'h00);
    wr(16'h0312, 8'hFF);
    rd_chk(16'h0310, 8'h61);
    foreach (rows[i])
    begin
      wr(16'h0310, rows[i].c0);
      wr(16'h0311, rows[i].c1);
      sa        = rows[i].s;
      da        = rows[i].d;
      vinv      = rows[i].vi;
      unk_en    = rows[i].uk;
      pf_en     = rows[i].pf;
      pkt_valid = 1'b1;
      @(negedge clk);
      pkt_valid = 1'b0;
      chk("vlan_enable", 48'(rows[i].c0[7]), 48'(vlan_en));
      chk("pkt_valid", 48'h1, 48'(o_valid));
      chk("pkt_flags", 48'(rows[i].exp), 48'({o_drop, o_host, o_unk, o_learn, o_rsvd}));
      chk("hash_index", 48'(exp_index(rows[i].d, rows[i].c0[1:0])), 48'(hidx));
      @(negedge clk);
      chk("pkt_idle", 48'h0, 48'({o_valid, o_drop, o_host, o_unk, o_learn, o_rsvd}));
    end
    pf_en = 6'h3F;
    wr(16'h0310, 8'h58);
    repeat (2) @(negedge clk);
    chk("age_count", 48'h3, 48'(age_cnt));
    chk("age_time", 48'd225, 48'(age_time));
    for (int k = 0; k < 4; k++)
    begin
      flush_opt = 2'(k);
      @(negedge clk);
      chk("flush_kind", 48'(k), 48'(flush_kind));
    end
    flush_opt = 2'b11;
    for (int j = 0; j < 2; j++)
    begin
      wr(16'h0311, j == 0 ? 8'h2C : 8'h1C);
      chk("flush_req", j == 0 ? 48'h2 : 48'h1, 48'({f_tab, f_mstp}));
      wr(16'h0311, 8'h0C);
      rd_chk(16'h0311, j == 0 ? 8'h2C : 8'h1C);
      flush_done = 1'b1;
      @(negedge clk);
      flush_done = 1'b0;
      @(negedge clk);
      chk("flush_clear", 48'h0, 48'({f_tab, f_mstp}));
    end
    flush_opt = 2'b00;
    wr(16'h0311, 8'h2C);
    @(negedge clk);
    chk("flush_none", 48'h0, 48'(f_tab));
    wr(16'h0311, 8'h0D);
    link_drop(6'h37, 6'h08);
    wr(16'h0311, 8'h0C);
    link_drop(6'h3E, 6'h00);
    age_period = 8'h02;
    repeat (2) @(negedge clk);
    chk("age_time", 48'd6, 48'(age_time));
    age_gap(40);
    wr(16'h0311, 8'h0E);
    age_gap(4);
    wr(16'h0311, 8'h08);
    cnt = 0;
    repeat (100)
    begin
      @(negedge clk);
      if (age_step !== 1'b0)
        cnt++;
    end
    chk("aging_off", 48'h0, 48'(cnt));
    // Reset in mid-run: both registers go back to their defaults
    age_period = 8'h4B;
    rst_n      = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd_chk(16'h0310, 8'h61);
    rd_chk(16'h0311, 8'h0C);
    chk("age_time", 48'h12C, 48'(age_time));
    chk("reset_outs", 48'h0, 48'({f_tab, f_mstp, vlan_en, port_flush}));
    end_of_test();
  end
endmodule : lookup_engine_control_regs_bench
`default_nettype wire
